// File: common/i2csf_pkg.sv
package i2csf_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_TRANSFER = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_CLEAR = 8'h1C;
  localparam logic [7:0] OFS_RX_BYTE = 8'h24;
  localparam logic [7:0] OFS_TX_BYTE = 8'h28;
  // Control register fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_STRETCH_DIS = 1;
  localparam int CTL_SLAVE_BYTE = 2;
  localparam int CTL_HOST_ADDR = 3;
  localparam int CTL_ALERT_EN = 4;
  localparam logic [4:0] CTL_RESET = 5'h00;
  // Transfer control register fields
  localparam int XFR_START = 13;
  localparam int XFR_STOP = 14;
  localparam int XFR_COUNT_LSB = 16;
  localparam int XFR_RELOAD = 24;
  localparam int XFR_AUTO_END = 25;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // Status register fields, shared by the clear register
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_TX_REQ = 1;
  localparam int ST_RX_FULL = 2;
  localparam int ST_ADDR_HIT = 3;
  localparam int ST_NACK = 4;
  localparam int ST_STOP = 5;
  localparam int ST_DONE = 6;
  localparam int ST_RELOAD = 7;
  localparam int ST_BUS_ERR = 8;
  localparam int ST_ARB_LOST = 9;
  localparam int ST_OVR = 10;
  localparam int ST_PEC_ERR = 11;
  localparam int ST_TIMEOUT = 12;
  localparam int ST_ALERT = 13;
  localparam int ST_BUSY = 15;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0001;
  localparam logic [7:0] TX_BYTE_RESET = 8'h00;
  localparam logic [7:0] RX_BYTE_RESET = 8'h00;
endpackage : i2csf_pkg

// File: design/i2csf_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module i2csf_status_flags #(
  parameter bit SMBUS_SUPPORT = 1'b1,
  parameter int COUNT_W = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Bus pins, asynchronous to clk_i
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic alert_n_i,
  // Events from the shift and protocol engine, same clock
  input wire logic master_mode_i,
  input wire logic tx_byte_taken_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic addr_match_i,
  input wire logic nack_rx_i,
  input wire logic byte_done_i,
  input wire logic byte_in_progress_i,
  input wire logic arb_lost_i,
  input wire logic overrun_i,
  input wire logic pec_mismatch_i,
  input wire logic idle_timeout_i,
  input wire logic ext_timeout_i,
  input wire logic start_sent_i,
  input wire logic stop_sent_i,
  // Control towards the engine
  output logic peripheral_enable_o,
  output logic stretch_disable_o,
  output logic start_req_o,
  output logic stop_req_o,
  output logic [COUNT_W-1:0] byte_count_o,
  output logic [7:0] tx_byte_o,
  output logic tx_byte_valid_o,
  output logic pec_nack_o
);

  // Control registers
  logic [4:0] control_reg;
  logic start_req_reg;
  logic stop_req_reg;
  logic [COUNT_W-1:0] byte_count_reg;
  logic count_reload_enable_reg;
  logic auto_end_select_reg;
  logic [COUNT_W-1:0] bytes_moved_reg;
  logic [7:0] tx_byte_reg;
  logic [7:0] rx_byte_reg;
  logic [31:0] rdata_reg;
  logic pec_nack_reg;
  logic enabled_once_reg;
  logic enable_prev_reg;
  logic tx_byte_valid_reg;

  // Status flags
  logic tx_buffer_empty_reg;
  logic tx_request_event_reg;
  logic rx_buffer_full_reg;
  logic own_address_hit_reg;
  logic not_ack_seen_reg;
  logic stop_seen_reg;
  logic transfer_done_reg;
  logic reload_done_reg;
  logic misplaced_condition_error_reg;
  logic arbitration_lost_reg;
  logic overrun_underrun_reg;
  logic packet_code_error_reg;
  logic clock_timeout_error_reg;
  logic alert_seen_reg;
  logic bus_busy_reg;
  logic took_part_reg;
  logic stop_clear_ok_reg;

  // Pin synchronisers
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_prev_reg;
  logic alert_meta_reg;
  logic alert_sync_reg;
  logic alert_prev_reg;

  // Decode
  wire peripheral_enable = control_reg[i2csf_pkg::CTL_ENABLE];
  wire stretch_disable = control_reg[i2csf_pkg::CTL_STRETCH_DIS];
  wire slave_byte_control = control_reg[i2csf_pkg::CTL_SLAVE_BYTE];
  wire host_address_enable = control_reg[i2csf_pkg::CTL_HOST_ADDR];
  wire alert_enable = control_reg[i2csf_pkg::CTL_ALERT_EN];
  wire wr_control = wr_i && (addr_i == i2csf_pkg::OFS_CONTROL);
  wire wr_transfer = wr_i && (addr_i == i2csf_pkg::OFS_TRANSFER);
  wire wr_status = wr_i && (addr_i == i2csf_pkg::OFS_STATUS);
  wire wr_clear = wr_i && (addr_i == i2csf_pkg::OFS_CLEAR);
  wire wr_tx_byte = wr_i && (addr_i == i2csf_pkg::OFS_TX_BYTE);
  wire rd_rx_byte = rd_i && (addr_i == i2csf_pkg::OFS_RX_BYTE);
  wire [COUNT_W-1:0] new_count = wdata_i[i2csf_pkg::XFR_COUNT_LSB +: COUNT_W];
  wire count_written_nonzero = wr_transfer && (new_count != '0);
  wire clr_addr_hit = wr_clear && wdata_i[i2csf_pkg::ST_ADDR_HIT];
  wire clr_nack = wr_clear && wdata_i[i2csf_pkg::ST_NACK];
  wire clr_stop = wr_clear && wdata_i[i2csf_pkg::ST_STOP];
  wire clr_bus_err = wr_clear && wdata_i[i2csf_pkg::ST_BUS_ERR];
  wire clr_arb = wr_clear && wdata_i[i2csf_pkg::ST_ARB_LOST];
  wire clr_ovr = wr_clear && wdata_i[i2csf_pkg::ST_OVR];
  wire clr_pec = wr_clear && wdata_i[i2csf_pkg::ST_PEC_ERR];
  wire clr_timeout = wr_clear && wdata_i[i2csf_pkg::ST_TIMEOUT];
  wire clr_alert = wr_clear && wdata_i[i2csf_pkg::ST_ALERT];

  // Bus condition detection on synchronised pins
  wire start_det = scl_sync_reg && sda_prev_reg && !sda_sync_reg;
  wire stop_det = scl_sync_reg && !sda_prev_reg && sda_sync_reg;
  wire alert_fall = alert_prev_reg && !alert_sync_reg;

  // Transmit byte handling
  wire tx_flush = wr_status && wdata_i[i2csf_pkg::ST_TX_EMPTY];
  // Byte register only loads while empty, so a write and a take never collide
  wire tx_load = wr_tx_byte && tx_buffer_empty_reg;
  // Every enable edge starts empty, since disable has already wiped the byte
  wire enable_rises = peripheral_enable && !enable_prev_reg;
  wire tx_empty_set = tx_byte_taken_i || tx_flush || enable_rises;
  wire tx_req_soft = wr_status && wdata_i[i2csf_pkg::ST_TX_REQ] && stretch_disable;

  // Byte counting
  wire [COUNT_W-1:0] bytes_inc = bytes_moved_reg + {{(COUNT_W-1){1'b0}}, 1'b1};
  wire count_hit = byte_done_i && (byte_count_reg != '0) && (bytes_inc == byte_count_reg);
  wire reload_allowed = master_mode_i || slave_byte_control;
  wire done_set = count_hit && !count_reload_enable_reg && !auto_end_select_reg;
  wire reload_set = count_hit && count_reload_enable_reg && reload_allowed;
  wire req_written = wr_transfer && (wdata_i[i2csf_pkg::XFR_START] || wdata_i[i2csf_pkg::XFR_STOP]);
  wire start_set = wr_transfer && wdata_i[i2csf_pkg::XFR_START];
  wire stop_set = wr_transfer && wdata_i[i2csf_pkg::XFR_STOP];

  // Event qualification
  wire addr_hit_set = addr_match_i;
  wire stop_set_flag = stop_det && (took_part_reg || master_mode_i || addr_match_i);
  wire stop_clear_eff = clr_stop && stop_clear_ok_reg;
  wire bus_err_set = (start_det || stop_det) && byte_in_progress_i;
  wire ovr_set = overrun_i && !master_mode_i && stretch_disable;
  wire pec_set = SMBUS_SUPPORT && pec_mismatch_i;
  wire timeout_set = SMBUS_SUPPORT && (idle_timeout_i || ext_timeout_i);
  wire alert_set = SMBUS_SUPPORT && host_address_enable && alert_enable && alert_fall;

  // Sticky flag: set wins over clear, disable wipes it
  function automatic logic sticky(input logic q, input logic set, input logic clr,
                                  input logic en);
    sticky = en && (set || (q && !clr));
  endfunction

  wire tx_empty_next = peripheral_enable ? (tx_empty_set || (tx_buffer_empty_reg && !tx_load))
                                         : (tx_buffer_empty_reg && !enabled_once_reg);
  wire tx_empty_rises = tx_empty_set && !tx_buffer_empty_reg;
  wire tx_req_next = sticky(tx_request_event_reg, tx_empty_rises || tx_req_soft, tx_load,
                            peripheral_enable);
  wire rx_full_next = sticky(rx_buffer_full_reg, rx_byte_valid_i, rd_rx_byte,
                             peripheral_enable);

  // Read mux
  wire [31:0] status_view = {16'h0000, bus_busy_reg, 1'b0, alert_seen_reg,
                             clock_timeout_error_reg, packet_code_error_reg,
                             overrun_underrun_reg, arbitration_lost_reg,
                             misplaced_condition_error_reg, reload_done_reg,
                             transfer_done_reg, stop_seen_reg, not_ack_seen_reg,
                             own_address_hit_reg, rx_buffer_full_reg,
                             tx_request_event_reg, tx_buffer_empty_reg};
  // Count field is eight bits; a wider counter would show only its low byte
  wire [7:0] count_view = 8'(byte_count_reg);
  wire [31:0] transfer_view = {6'h00, auto_end_select_reg, count_reload_enable_reg,
                               count_view, 1'b0, stop_req_reg, start_req_reg, 13'h0000};
  wire [31:0] read_mux =
    (addr_i == i2csf_pkg::OFS_STATUS) ? status_view :
    (addr_i == i2csf_pkg::OFS_CONTROL) ? {27'h0000000, control_reg} :
    (addr_i == i2csf_pkg::OFS_TRANSFER) ? transfer_view :
    (addr_i == i2csf_pkg::OFS_RX_BYTE) ? {24'h000000, rx_byte_reg} :
    (addr_i == i2csf_pkg::OFS_TX_BYTE) ? {24'h000000, tx_byte_reg} :
    32'h0000_0000;

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      alert_meta_reg <= 1'b1;
      alert_sync_reg <= 1'b1;
      alert_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_i;
      scl_sync_reg <= scl_meta_reg;
      sda_meta_reg <= sda_i;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      alert_meta_reg <= alert_n_i;
      alert_sync_reg <= alert_meta_reg;
      alert_prev_reg <= alert_sync_reg;
    end
  end

  // Control and transfer registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      control_reg <= i2csf_pkg::CTL_RESET;
      byte_count_reg <= COUNT_W'(i2csf_pkg::COUNT_RESET);
      count_reload_enable_reg <= 1'b0;
      auto_end_select_reg <= 1'b0;
      start_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
      enabled_once_reg <= 1'b0;
      enable_prev_reg <= 1'b0;
    end else begin
      if (wr_control) begin
        control_reg <= wdata_i[4:0];
      end
      if (wr_transfer) begin
        byte_count_reg <= new_count;
        count_reload_enable_reg <= wdata_i[i2csf_pkg::XFR_RELOAD];
        auto_end_select_reg <= wdata_i[i2csf_pkg::XFR_AUTO_END];
      end
      // Software set wins over the engine taking the request
      start_req_reg <= peripheral_enable &&
                       (start_set || (start_req_reg && !start_sent_i && !clr_addr_hit));
      stop_req_reg <= peripheral_enable && (stop_set || (stop_req_reg && !stop_sent_i));
      if (peripheral_enable) begin
        enabled_once_reg <= 1'b1;
      end
      enable_prev_reg <= peripheral_enable;
    end
  end

  // Data bytes, byte counter and read port
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_byte_reg <= i2csf_pkg::TX_BYTE_RESET;
      rx_byte_reg <= i2csf_pkg::RX_BYTE_RESET;
      bytes_moved_reg <= '0;
      rdata_reg <= 32'h0000_0000;
      pec_nack_reg <= 1'b0;
    end else begin
      if (tx_flush || !peripheral_enable) begin
        tx_byte_reg <= i2csf_pkg::TX_BYTE_RESET;
      end else if (tx_load) begin
        tx_byte_reg <= wdata_i[7:0];
      end
      if (rx_byte_valid_i) begin
        rx_byte_reg <= rx_byte_i;
      end
      // Counter restarts on a new request or reload so the hit lands on the last byte
      if (req_written || count_written_nonzero || !peripheral_enable) begin
        bytes_moved_reg <= '0;
      end else if (count_hit) begin
        bytes_moved_reg <= '0;
      end else if (byte_done_i) begin
        bytes_moved_reg <= bytes_inc;
      end
      rdata_reg <= rd_i ? read_mux : 32'h0000_0000;
      pec_nack_reg <= pec_set && peripheral_enable;
    end
  end

  // Status flags
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_buffer_empty_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_TX_EMPTY];
      tx_byte_valid_reg <= 1'b0;
      tx_request_event_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_TX_REQ];
      rx_buffer_full_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_RX_FULL];
      own_address_hit_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_ADDR_HIT];
      not_ack_seen_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_NACK];
      stop_seen_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_STOP];
      transfer_done_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_DONE];
      reload_done_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_RELOAD];
      misplaced_condition_error_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_BUS_ERR];
      arbitration_lost_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_ARB_LOST];
      overrun_underrun_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_OVR];
      packet_code_error_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_PEC_ERR];
      clock_timeout_error_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_TIMEOUT];
      alert_seen_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_ALERT];
      bus_busy_reg <= i2csf_pkg::STATUS_RESET[i2csf_pkg::ST_BUSY];
      took_part_reg <= 1'b0;
      stop_clear_ok_reg <= 1'b0;
    end else begin
      tx_buffer_empty_reg <= tx_empty_next;
      // Own flop keeps the valid output registered rather than behind an inverter
      tx_byte_valid_reg <= !tx_empty_next;
      tx_request_event_reg <= tx_req_next;
      rx_buffer_full_reg <= rx_full_next;
      own_address_hit_reg <= sticky(own_address_hit_reg, addr_hit_set, clr_addr_hit,
                                    peripheral_enable);
      not_ack_seen_reg <= sticky(not_ack_seen_reg, nack_rx_i, clr_nack,
                                 peripheral_enable);
      stop_seen_reg <= sticky(stop_seen_reg, stop_set_flag, stop_clear_eff,
                              peripheral_enable);
      transfer_done_reg <= sticky(transfer_done_reg, done_set, req_written,
                                  peripheral_enable);
      reload_done_reg <= sticky(reload_done_reg, reload_set, count_written_nonzero,
                                peripheral_enable);
      misplaced_condition_error_reg <= sticky(misplaced_condition_error_reg, bus_err_set,
                                              clr_bus_err, peripheral_enable);
      arbitration_lost_reg <= sticky(arbitration_lost_reg, arb_lost_i, clr_arb,
                                     peripheral_enable);
      overrun_underrun_reg <= sticky(overrun_underrun_reg, ovr_set, clr_ovr,
                                     peripheral_enable);
      packet_code_error_reg <= SMBUS_SUPPORT &&
                               sticky(packet_code_error_reg, pec_set, clr_pec,
                                      peripheral_enable);
      clock_timeout_error_reg <= SMBUS_SUPPORT &&
                                 sticky(clock_timeout_error_reg, timeout_set, clr_timeout,
                                        peripheral_enable);
      alert_seen_reg <= SMBUS_SUPPORT &&
                        sticky(alert_seen_reg, alert_set, clr_alert,
                               peripheral_enable);
      // A stop clears busy; a start in the same cycle cannot happen on one edge of sda
      bus_busy_reg <= peripheral_enable &&
                      (start_det || (bus_busy_reg && !stop_det));
      // Participation lasts from our first involvement to the closing stop
      took_part_reg <= peripheral_enable && !stop_det &&
                       (took_part_reg || master_mode_i || addr_match_i);
      // Clear permission is kept past the stop, until the next transfer begins
      if (!peripheral_enable) begin
        stop_clear_ok_reg <= 1'b0;
      end else if ((stop_det && master_mode_i) || addr_match_i) begin
        stop_clear_ok_reg <= 1'b1;
      end else if (start_det && !bus_busy_reg) begin
        stop_clear_ok_reg <= 1'b0;
      end
    end
  end

  // Outputs straight from flip-flops
  assign rdata_o = rdata_reg;
  assign peripheral_enable_o = control_reg[i2csf_pkg::CTL_ENABLE];
  assign stretch_disable_o = control_reg[i2csf_pkg::CTL_STRETCH_DIS];
  assign start_req_o = start_req_reg;
  assign stop_req_o = stop_req_reg;
  assign byte_count_o = byte_count_reg;
  assign tx_byte_o = tx_byte_reg;
  assign tx_byte_valid_o = tx_byte_valid_reg;
  assign pec_nack_o = pec_nack_reg;

endmodule // i2csf_status_flags
`default_nettype wire

// File: dv/i2csf_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2csf_bus_model (
  output logic scl_o,
  output logic sda_o,
  output logic alert_n_o
);
  // Lines rest at their pull-up level; the link clock only moves inside frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    alert_n_o = 1'b1;
  end
  task automatic start_c;
    sda_o = 1'b0;
    #100;
    scl_o = 1'b0;
    #100;
  endtask
  task automatic stop_c;
    sda_o = 1'b0;
    #100;
    scl_o = 1'b1;
    #100;
    sda_o = 1'b1;
    #100;
  endtask
  task automatic alert_c;
    alert_n_o = 1'b0;
    #400;
    alert_n_o = 1'b1;
    #400;
  endtask
endmodule // i2csf_bus_model
`default_nettype wire

// File: dv/i2csf_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module i2csf_status_monitor #(
  parameter bit SMBUS_SUPPORT = 1'b1,
  parameter int COUNT_W = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic tx_byte_taken_i,
  input wire logic pec_mismatch_i,
  input wire logic peripheral_enable_o,
  input wire logic start_req_o,
  input wire logic stretch_disable_o,
  input wire logic stop_req_o,
  input wire logic [COUNT_W-1:0] byte_count_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic tx_byte_valid_o,
  input wire logic pec_nack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire wr_tx = wr_i && addr_i == i2csf_pkg::OFS_TX_BYTE;
  wire wr_st = wr_i && addr_i == i2csf_pkg::OFS_STATUS;
  wire wr_ct = wr_i && addr_i == i2csf_pkg::OFS_CONTROL;
  wire wr_cl = wr_i && addr_i == i2csf_pkg::OFS_CLEAR;
  wire wr_xf = wr_i && addr_i == i2csf_pkg::OFS_TRANSFER;
  wire [7:0] wlo = wdata_i[7:0];
  sequence pec_seen;
    pec_mismatch_i && peripheral_enable_o && SMBUS_SUPPORT;
  endsequence
  sequence off_read;
    (!peripheral_enable_o)[*2] ##0 (rd_i && addr_i == i2csf_pkg::OFS_STATUS);
  endsequence
  tx_load_a: assert property (
    wr_tx && peripheral_enable_o && !tx_byte_valid_o |=> tx_byte_valid_o && tx_byte_o == $past(wlo))
    else $error("tx byte not loaded");
  tx_flush_a: assert property (
    wr_st && wdata_i[0] && peripheral_enable_o |=> !tx_byte_valid_o)
    else $error("tx flush ignored");
  tx_taken_a: assert property (
    tx_byte_taken_i && peripheral_enable_o && !wr_tx && !wr_ct |=> !tx_byte_valid_o)
    else $error("tx byte still valid after take");
  pec_nack_a: assert property (pec_seen |=> pec_nack_o)
    else $error("no automatic nack");
  pec_cause_a: assert property (pec_nack_o |-> $past(pec_mismatch_i))
    else $error("nack without mismatch");
  start_clear_a: assert property (wr_cl && wdata_i[3] |=> !start_req_o)
    else $error("start request survived clear");
  off_read_a: assert property (off_read |=> rdata_o[15:1] == 15'h0000)
    else $error("flag set while disabled");
  ctl_echo_a: assert property (wr_ct |=> stretch_disable_o == $past(wdata_i[1]))
    else $error("stretch disable not applied");
  count_echo_a: assert property (
    wr_xf |=> byte_count_o == $past(wdata_i[i2csf_pkg::XFR_COUNT_LSB +: COUNT_W]))
    else $error("byte count not applied");
  stop_req_a: assert property (wr_xf && wdata_i[14] && peripheral_enable_o |=> stop_req_o)
    else $error("stop request not raised");
  read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside answer cycle");
endmodule // i2csf_status_monitor
bind i2csf_status_flags i2csf_status_monitor #(.SMBUS_SUPPORT(SMBUS_SUPPORT), .COUNT_W(COUNT_W))
  i2csf_status_monitor_inst (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .tx_byte_taken_i, .pec_mismatch_i, .peripheral_enable_o, .start_req_o, .stretch_disable_o,
  .stop_req_o, .byte_count_o, .tx_byte_o, .tx_byte_valid_o, .pec_nack_o);
`default_nettype wire

// File: dv/i2csf_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2csf_status_flags_tb;
  localparam logic [7:0] ST = i2csf_pkg::OFS_STATUS;
  localparam logic [7:0] CT = i2csf_pkg::OFS_CONTROL;
  localparam logic [7:0] CL = i2csf_pkg::OFS_CLEAR;
  localparam logic [7:0] XF = i2csf_pkg::OFS_TRANSFER;
  localparam logic [7:0] TX = i2csf_pkg::OFS_TX_BYTE;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mm = 1'b0, bip = 1'b0;
  logic [7:0] addr = 8'h00, rxb = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [9:0] ev = 10'h000;
  wire scl, sda, aln;
  int err_count = 0;
  int n_compared = 0;
  int eb[7] = '{4, 3, 9, 10, 11, 12, 12};
  initial begin
    forever #12.5 clk = ~clk;
  end
  i2csf_bus_model i2csf_bus_model_inst (.scl_o(scl), .sda_o(sda), .alert_n_o(aln));
  i2csf_status_flags i2csf_status_flags_inst (.clk_i(clk), .sys_rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .scl_i(scl), .sda_i(sda),
    .alert_n_i(aln), .master_mode_i(mm), .tx_byte_taken_i(ev[8]), .rx_byte_valid_i(ev[9]),
    .rx_byte_i(rxb), .addr_match_i(ev[1]), .nack_rx_i(ev[0]), .byte_done_i(ev[7]),
    .byte_in_progress_i(bip), .arb_lost_i(ev[2]), .overrun_i(ev[3]), .pec_mismatch_i(ev[4]),
    .idle_timeout_i(ev[5]), .ext_timeout_i(ev[6]), .start_sent_i(1'b0), .stop_sent_i(1'b0),
    .peripheral_enable_o(), .stretch_disable_o(), .start_req_o(), .stop_req_o(),
    .byte_count_o(), .tx_byte_o(), .tx_byte_valid_o(), .pec_nack_o());
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    n_compared++;
    if ((rdata & m) !== e) begin
      err_count++;
      $display("CHECK FAILED %0t read %h got %h", $time, a, rdata);
    end
  endtask
  // Write, then read back the status bits under the mask
  task automatic step(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [31:0] e);
    wr_reg(a, d);
    chk(ST, m, e);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  task automatic final_report;
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk(ST, 32'hFFFF_FFFF, 32'h0000_0001);
    step(CT, 32'h3, 32'h1, 32'h1);
    step(TX, 32'hA5, 32'h1, 32'h0);
    step(ST, 32'h1, 32'h1, 32'h1);
    wr_reg(TX, 32'h5A);
    pulse(8);
    chk(ST, 32'h3, 32'h3);
    step(TX, 32'h11, 32'h3, 32'h0);
    step(ST, 32'h2, 32'h2, 32'h2);
    // Nobody has taken part yet, so this stop must leave the stop flag low
    i2csf_bus_model_inst.start_c();
    repeat (8) @(posedge clk);
    chk(ST, 32'h8000, 32'h8000);
    i2csf_bus_model_inst.stop_c();
    repeat (8) @(posedge clk);
    chk(ST, 32'h8020, 32'h0);
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      repeat (4) @(posedge clk);
      chk(ST, 32'h1 << eb[i], 32'h1 << eb[i]);
      step(CL, 32'h1 << eb[i], 32'h1 << eb[i], 32'h0);
    end
    rxb <= 8'h3C;
    pulse(9);
    chk(ST, 32'h4, 32'h4);
    chk(i2csf_pkg::OFS_RX_BYTE, 32'hFF, 32'h3C);
    chk(ST, 32'h4, 32'h0);
    i2csf_bus_model_inst.start_c();
    pulse(1);
    i2csf_bus_model_inst.stop_c();
    repeat (8) @(posedge clk);
    chk(ST, 32'h20, 32'h20);
    step(CL, 32'h28, 32'h28, 32'h0);
    bip <= 1'b1;
    i2csf_bus_model_inst.start_c();
    repeat (8) @(posedge clk);
    chk(ST, 32'h100, 32'h100);
    // Took part as master without issuing the stop: its clear must be refused
    mm <= 1'b1;
    @(posedge clk);
    mm <= 1'b0;
    @(negedge clk);
    i2csf_bus_model_inst.stop_c();
    bip <= 1'b0;
    step(CL, 32'h120, 32'h120, 32'h20);
    wr_reg(XF, 32'h0002_0000);
    pulse(7);
    chk(ST, 32'h40, 32'h0);
    pulse(7);
    chk(ST, 32'hC0, 32'h40);
    step(XF, 32'h0000_6000, 32'h40, 32'h0);
    step(CL, 32'h8, 32'h8, 32'h0);
    chk(XF, 32'h6000, 32'h4000);
    mm <= 1'b1;
    wr_reg(XF, 32'h0101_0000);
    pulse(7);
    chk(ST, 32'hC0, 32'h80);
    step(XF, 32'h0101_0000, 32'h80, 32'h0);
    mm <= 1'b0;
    wr_reg(XF, 32'h0101_0000);
    pulse(7);
    chk(ST, 32'h80, 32'h0);
    wr_reg(CT, 32'h9);
    i2csf_bus_model_inst.alert_c();
    chk(ST, 32'h2000, 32'h0);
    wr_reg(CT, 32'h19);
    i2csf_bus_model_inst.alert_c();
    chk(ST, 32'h2000, 32'h2000);
    step(CL, 32'h2000, 32'h2000, 32'h0);
    pulse(0);
    step(CT, 32'h0, 32'hFFFF, 32'h0);
    step(CT, 32'h1, 32'h1, 32'h1);
    final_report();
  end
  // Whole sequence needs about 400 cycles; this cuts a hang short
  initial begin
    #400000;
    err_count++;
    final_report();
  end
endmodule // i2csf_status_flags_tb
`default_nettype wire
